// >>> design/sbcsp_pkg.sv
// shared constants and types for the sbc spi control and status link
package sbcsp_pkg;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] BITS_PER_XFER = 4'h8;
  localparam logic [CNT_W-1:0] BITS_OVER = 4'h9;
  // control byte fields
  localparam int CB_PU_DIS = 5;
  localparam int CB_HS3 = 4;
  localparam int CB_HS2 = 3;
  localparam int CB_HS1 = 2;
  localparam int CB_OP_LO = 0;
  localparam logic [1:0] SLEW_NORMAL = 2'h0;
  localparam logic [1:0] SLEW_LOWPWR = 2'h3;
  localparam logic [1:0] OP_WDCLR = 2'h2;
  localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h03;
  localparam logic [BYTE_W-1:0] CTRL_RST_KEEP = 8'h23;
  localparam logic [BYTE_W-1:0] LP_CMD_MASK = 8'hDE;
  localparam logic [BYTE_W-1:0] LP_CMD_VALUE = 8'hC0;
  // status byte fields
  localparam int ST_UV = 4;
  localparam int ST_W2 = 1;
  localparam int ST_W1 = 0;
  localparam int ST_BUS = 6;
  // synchroniser lanes
  localparam int PIN_SCLK = 2;
  localparam int PIN_CS = 1;
  localparam int PIN_MOSI = 0;
  localparam logic [2:0] PIN_IDLE = 3'h2;
  // host register map
  localparam logic [7:0] REG_TX = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_DIV = 8'h08;
  localparam int HALF_W = 8;
  localparam int HALF_DEF = 8;
  localparam int HALF_MIN = 8;
  localparam int CS_GAP_NS = 15000;
  localparam int PCLK_NS = 8;
  localparam int CS_GAP_CYC = (CS_GAP_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int GAP_W = 16;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_STOP = 2'b01,
    MODE_SLEEP = 2'b10
  } sbcsp_mode_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_HIGH = 3'b010,
    H_LOW = 3'b011,
    H_TRAIL = 3'b100,
    H_GAP = 3'b101
  } sbcsp_hstate_t;
endpackage : sbcsp_pkg

// >>> design/sbcsp_if.sv
// spi link between the host controller and the device
`timescale 1ns/1ns
interface sbcsp_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : sbcsp_if

// >>> design/sbcsp_device.sv
// device end: control byte decode and status snapshot over spi
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module sbcsp_device (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // spi link
  sbcsp_if.device link,
  // device reset and switch gate
  input wire logic dev_reset,
  input wire logic pwm_gate,
  // live conditions
  input wire logic bus_wake_flag,
  input wire logic bus_fault_flag,
  input wire logic supply_overvoltage,
  input wire logic supply_undervoltage_flag,
  input wire logic battery_fail_flag,
  input wire logic regulator_temp_warning,
  input wire logic switch_thermal_shutdown_flag,
  input wire logic wake_input_one,
  input wire logic wake_input_two,
  // control outputs
  output logic [sbcsp_pkg::BYTE_W-1:0] control_byte,
  output logic [1:0] slew_rate,
  output logic bus_pullup_connected,
  output logic switch_on_three,
  output logic switch_on_two,
  output logic switch_on_one,
  output logic watchdog_clear,
  output sbcsp_pkg::sbcsp_mode_t op_mode
);
  import sbcsp_pkg::*;

  typedef struct packed {
    logic [2:0] st1;
    logic [2:0] st2;
    logic [2:0] st3;
    logic [2:0] lvl;
    logic [CNT_W-1:0] cnt;
    logic [BYTE_W-1:0] shin;
    logic [BYTE_W-1:0] shout;
    logic [BYTE_W-1:0] ctrl;
    logic miso;
    logic [1:0] slew;
    logic armed;
    logic armed_op;
    sbcsp_mode_t mode;
    logic [6:0] int_lat;
    logic [6:0] prev;
    logic first_read;
    logic wd_clear;
    logic pullup_on;
    logic [2:0] sw;
  } sbcsp_dev_state_t;

  sbcsp_dev_state_t r;
  sbcsp_dev_state_t n;

  logic [2:0] pins;
  assign pins = {link.sclk, link.cs_n, link.mosi};

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [2:0] differ;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic [6:0] live;
    logic [6:0] ev;
    logic [6:0] bits;
    logic [BYTE_W-1:0] b;
    logic lp_cmd;
    logic woke;
    differ = 3'h0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    live = 7'h00;
    ev = 7'h00;
    bits = 7'h00;
    b = 8'h00;
    lp_cmd = 1'b0;
    woke = 1'b0;
    n = r;
    n.wd_clear = 1'b0;

    // three-stage pin sampling; a level counts once stages two and three agree
    n.st1 = pins;
    n.st2 = r.st1;
    n.st3 = r.st2;
    differ = r.st2 ^ r.st3;
    n.lvl = (~differ & r.st2) | (differ & r.lvl);
    sclk_rise = n.lvl[PIN_SCLK] & ~r.lvl[PIN_SCLK] & ~r.lvl[PIN_CS];
    sclk_fall = ~n.lvl[PIN_SCLK] & r.lvl[PIN_SCLK] & ~r.lvl[PIN_CS];
    cs_fall = ~n.lvl[PIN_CS] & r.lvl[PIN_CS];
    cs_rise = n.lvl[PIN_CS] & ~r.lvl[PIN_CS];

    // live flags in status order, bit 6 down to 0
    live = {bus_wake_flag | bus_fault_flag,
            supply_overvoltage, supply_undervoltage_flag,
            regulator_temp_warning, switch_thermal_shutdown_flag,
            wake_input_two, wake_input_one};
    n.prev = live;
    // faults latch on their rise, wake inputs on any change
    ev = (live & ~r.prev);
    ev[ST_W2] = live[ST_W2] ^ r.prev[ST_W2];
    ev[ST_W1] = live[ST_W1] ^ r.prev[ST_W1];
    n.int_lat = r.int_lat | ev;

    // a wake source takes the device back to normal
    woke = ev[ST_BUS] | ev[ST_W2] | ev[ST_W1];
    if (r.mode != MODE_NORMAL && woke) begin
      n.mode = MODE_NORMAL;
    end

    if (cs_fall) begin
      bits = (r.int_lat != 7'h00) ? r.int_lat : live;
      if (r.first_read) begin
        bits[ST_UV] = battery_fail_flag;
      end
      n.shout = {(r.int_lat != 7'h00), bits};
      n.miso = (r.int_lat != 7'h00);
      // events in this very cycle survive the clear
      n.int_lat = ev;
      n.first_read = 1'b0;
      n.cnt = '0;
    end

    // data is sampled on the rise and changed on the fall
    if (sclk_rise) begin
      n.shin = {r.shin[BYTE_W-2:0], r.lvl[PIN_MOSI]};
      if (r.cnt != BITS_OVER) begin
        n.cnt = r.cnt + 4'h1;
      end
    end
    if (sclk_fall) begin
      n.miso = r.shout[BYTE_W-2];
      n.shout = {r.shout[BYTE_W-2:0], 1'b0};
    end

    // a byte is taken only when exactly eight bits arrived
    if (cs_rise && r.cnt == BITS_PER_XFER) begin
      b = r.shin;
      n.ctrl = b;
      if (b[1:0] == OP_WDCLR) begin
        // no closed window, the clear always counts
        n.wd_clear = 1'b1;
        n.ctrl[CB_OP_LO] = 1'b1;
      end
      if (b[BYTE_W-1:BYTE_W-2] != SLEW_LOWPWR) begin
        n.slew = b[BYTE_W-1:BYTE_W-2];
      end
      lp_cmd = (b & LP_CMD_MASK) == LP_CMD_VALUE;
      if (lp_cmd) begin
        if (r.armed && r.armed_op == b[CB_OP_LO]) begin
          n.mode = b[CB_OP_LO] ? MODE_STOP : MODE_SLEEP;
          n.armed = 1'b0;
        end else begin
          // the first qualifying byte only arms the entry
          n.armed = 1'b1;
          n.armed_op = b[CB_OP_LO];
        end
      end else begin
        n.armed = 1'b0;
      end
    end

    // device reset keeps the pullup bit, which only power-on clears
    if (dev_reset) begin
      n.ctrl = r.ctrl & CTRL_RST_KEEP;
      n.ctrl[1:0] = CTRL_RESET[1:0];
      n.slew = SLEW_NORMAL;
      n.armed = 1'b0;
      n.mode = MODE_NORMAL;
      n.first_read = 1'b1;
    end

    // switches are off outside normal mode
    n.sw[2] = r.ctrl[CB_HS3] && r.mode == MODE_NORMAL;
    n.sw[1] = r.ctrl[CB_HS2] && pwm_gate && r.mode == MODE_NORMAL;
    n.sw[0] = r.ctrl[CB_HS1] && pwm_gate && r.mode == MODE_NORMAL;
    n.pullup_on = !(r.mode != MODE_NORMAL && r.ctrl[CB_PU_DIS]);
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st1 <= PIN_IDLE;
      r.st2 <= PIN_IDLE;
      r.st3 <= PIN_IDLE;
      r.lvl <= PIN_IDLE;
      r.ctrl <= CTRL_RESET;
      r.slew <= SLEW_NORMAL;
      r.mode <= MODE_NORMAL;
      r.first_read <= 1'b1;
      r.pullup_on <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign link.miso = r.miso;
  assign control_byte = r.ctrl;
  assign slew_rate = r.slew;
  assign bus_pullup_connected = r.pullup_on;
  assign switch_on_three = r.sw[2];
  assign switch_on_two = r.sw[1];
  assign switch_on_one = r.sw[0];
  assign watchdog_clear = r.wd_clear;
  assign op_mode = r.mode;
endmodule : sbcsp_device

// >>> design/sbcsp_host.sv
// host end: apb-driven spi master for the control and status byte
`timescale 1ns/1ns
module sbcsp_host #(
  parameter int HALF_CYC = sbcsp_pkg::HALF_DEF,
  parameter int GAP_CYC = sbcsp_pkg::CS_GAP_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // spi link
  sbcsp_if.host link
);
  import sbcsp_pkg::*;

  // refused at elaboration: a half period under the minimum, no gap, or more than the divider and gap counters hold
  if (HALF_CYC < HALF_MIN || HALF_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 65535) begin : g_bad_timing
    $error("sbcsp_host: timing parameter out of range");
  end

  localparam logic [HALF_W-1:0] HALF_RST = HALF_W'(HALF_CYC);
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_CYC - 1);

  typedef struct packed {
    sbcsp_hstate_t st;
    logic [HALF_W-1:0] div;
    logic [HALF_W-1:0] hcnt;
    logic [GAP_W-1:0] gcnt;
    logic [CNT_W-1:0] nbit;
    logic [BYTE_W-1:0] tx;
    logic [BYTE_W-1:0] shtx;
    logic [BYTE_W-1:0] rx;
    logic [2:0] ms;
    logic miso_lvl;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sbcsp_host_state_t;

  sbcsp_host_state_t r;
  sbcsp_host_state_t n;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic busy;
    logic half_done;
    logic start;
    logic acc;
    busy = r.st != H_IDLE;
    half_done = r.hcnt == r.div - 8'h01;
    start = 1'b0;
    acc = psel && penable;
    n = r;
    n.hcnt = half_done ? 8'h00 : r.hcnt + 8'h01;
    // miso crosses in: three stages, taken when two and three agree
    n.ms = {r.ms[1:0], link.miso};
    if (r.ms[1] == r.ms[2]) begin
      n.miso_lvl = r.ms[1];
    end

    // apb: one wait state, error decided in the cycle before the answer
    n.pready = acc && !r.pready;
    n.pslverr = 1'b0;
    if (acc && !r.pready) begin
      n.prdata = 32'h0000_0000;
      case (paddr)
        REG_TX: begin
          n.prdata = {24'h00_0000, r.tx};
          n.pslverr = pwrite && busy;
        end
        REG_STAT: n.prdata = {23'h00_0000, busy, r.rx};
        REG_DIV: begin
          n.prdata = {24'h00_0000, r.div};
          n.pslverr = pwrite && (busy || pwdata[HALF_W-1:0] < HALF_W'(HALF_MIN));
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    if (acc && r.pready && pwrite && !r.pslverr) begin
      // one whole byte per write; sleep and stop codes are never split
      if (paddr == REG_TX) begin
        n.tx = pwdata[BYTE_W-1:0];
        start = 1'b1;
      end
      if (paddr == REG_DIV) begin
        n.div = pwdata[HALF_W-1:0];
      end
    end

    ////////////////////////////////////////////////////////////////
    case (r.st)
      H_IDLE: begin
        if (start) begin
          n.cs_n = 1'b0;
          n.shtx = pwdata[BYTE_W-1:0];
          n.mosi = pwdata[BYTE_W-1];
          n.nbit = '0;
          n.hcnt = 8'h00;
          n.st = H_LEAD;
        end
      end
      H_LEAD, H_LOW: begin
        if (half_done) begin
          n.sclk = 1'b1;
          // settled level of this very edge; the device answers four cycles after our fall
          // and its answer settles here four cycles after it, so the minimum half period has no slack
          n.rx = {r.rx[BYTE_W-2:0], n.miso_lvl};
          n.nbit = r.nbit + 4'h1;
          n.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_done) begin
          n.sclk = 1'b0;
          if (r.nbit == BITS_PER_XFER) begin
            n.st = H_TRAIL;
          end else begin
            n.shtx = {r.shtx[BYTE_W-2:0], 1'b0};
            n.mosi = r.shtx[BYTE_W-2];
            n.st = H_LOW;
          end
        end
      end
      H_TRAIL: begin
        if (half_done) begin
          n.cs_n = 1'b1;
          n.gcnt = '0;
          n.st = H_GAP;
        end
      end
      H_GAP: begin
        // no new frame until the chip-select spacing has passed
        n.gcnt = r.gcnt + 16'h0001;
        if (r.gcnt == GAP_LAST) begin
          n.st = H_IDLE;
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= H_IDLE;
      r.div <= HALF_RST;
      r.cs_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.mosi;
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
endmodule : sbcsp_host

// >>> test/sbcsp_monitor.sv
// wire checker for the spi link between the two ends
`timescale 1ns/1ns
module sbcsp_monitor #(
  parameter int HALF = 8,
  parameter int GAP = 20
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // spi wire
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_reg;
  logic cs_reg;
  logic [3:0] rise_reg;
  logic [3:0] rise_next;
  logic [15:0] gap_reg;
  logic [15:0] gap_next;

  always_comb begin
    rise_next = rise_reg;
    gap_next = (gap_reg == 16'hFFFF) ? gap_reg : gap_reg + 16'h0001;
    if (!cs_n && sclk && !sclk_reg) begin
      rise_next = rise_reg + 4'h1;
    end
    if (cs_n) begin
      rise_next = 4'h0;
    end
    if (cs_n && !cs_reg) begin
      gap_next = 16'h0000;
    end
  end

  // spacing counter starts saturated so the first frame is never flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_reg <= 1'b0;
      cs_reg <= 1'b1;
      rise_reg <= 4'h0;
      gap_reg <= 16'hFFFF;
    end else begin
      sclk_reg <= sclk;
      cs_reg <= cs_n;
      rise_reg <= rise_next;
      gap_reg <= gap_next;
    end
  end

  ////////////////////////////////////////
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  frame_start_a: assert property ($fell(cs_n) |=> !sclk [*4])
    else $error("sclk not low after select");
  mosi_stable_a: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  miso_stable_a: assert property (sclk |-> $stable(miso))
    else $error("miso moved while sclk high");
  high_phase_a: assert property ($rose(sclk) |=> sclk [*7])
    else $error("sclk high phase short");
  low_phase_a: assert property ($fell(sclk) && !cs_n |=> !sclk [*7])
    else $error("sclk low phase short");
  bit_count_a: assert property ($rose(cs_n) |-> rise_reg == 4'h8)
    else $error("frame not eight clocks");
  cs_spacing_a: assert property ($rose(cs_n) |-> gap_reg >= GAP + 16 * HALF)
    else $error("select rises too close");

  cover property ($fell(cs_n));
  cover property ($rose(cs_n) && rise_reg == 4'h8);
  cover property ($rose(sclk) && miso);
endmodule : sbcsp_monitor

// >>> test/tb.sv
// self-checking bench joining host and device ends over the spi link
`timescale 1ns/1ns
module tb;
  import sbcsp_pkg::*;
  typedef struct packed {
    logic [7:0] ctl;
    logic [8:0] flg;
    logic pwm;
    logic [7:0] ectl;
    logic [1:0] eslw;
    logic [3:0] eout;
    logic [1:0] emod;
    logic [7:0] est;
  } sbcsp_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dev_reset = 1'b0;
  logic pwm_gate = 1'b1;
  // flags: bus wake, bus fault, over, under, temp, switch temp, wake two, wake one, battery
  logic [8:0] flg = 9'h001;
  logic [7:0] control_byte;
  logic [1:0] slew_rate;
  logic pu_con, sw3, sw2, sw1, wd_clr;
  sbcsp_mode_t op_mode;
  int err_count = 0;
  int num_checks = 0;
  int wd_cnt = 0;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] mo_sh;
  logic [7:0] mi_sh;
  sbcsp_row_t rows [13] = '{
    '{8'h1F, 9'h001, 1'b1, 8'h1F, 2'h0, 4'hF, 2'h0, 8'h10}, '{8'h5E, 9'h041, 1'b0, 8'h5F, 2'h1, 4'hC, 2'h0, 8'hA0},
    '{8'h8B, 9'h041, 1'b1, 8'h8B, 2'h2, 4'hA, 2'h0, 8'h20}, '{8'hC3, 9'h07B, 1'b1, 8'hC3, 2'h2, 4'h8, 2'h0, 8'h9D},
    '{8'hC0, 9'h07B, 1'b1, 8'hC0, 2'h2, 4'h8, 2'h0, 8'h3D}, '{8'hC0, 9'h07B, 1'b1, 8'hC0, 2'h2, 4'h8, 2'h2, 8'h3D},
    '{8'hE1, 9'h07F, 1'b1, 8'hE1, 2'h2, 4'h8, 2'h0, 8'h82}, '{8'hE1, 9'h07F, 1'b1, 8'hE1, 2'h2, 4'h0, 2'h1, 8'h3F},
    '{8'h03, 9'h17F, 1'b1, 8'h03, 2'h0, 4'h8, 2'h0, 8'hC0}, '{8'h02, 9'h001, 1'b1, 8'h03, 2'h0, 4'h8, 2'h0, 8'h83},
    '{8'hC0, 9'h001, 1'b1, 8'hC0, 2'h0, 4'h8, 2'h0, 8'h00}, '{8'h03, 9'h001, 1'b1, 8'h03, 2'h0, 4'h8, 2'h0, 8'h00},
    '{8'hC0, 9'h001, 1'b1, 8'hC0, 2'h0, 4'h8, 2'h0, 8'h00}};

  sbcsp_if link ();
  sbcsp_host #(.GAP_CYC(20)) sbcsp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  sbcsp_device sbcsp_device_i (.pclk(pclk), .presetn(presetn), .link(link), .dev_reset(dev_reset),
    .pwm_gate(pwm_gate), .bus_wake_flag(flg[8]), .bus_fault_flag(flg[7]), .supply_overvoltage(flg[6]),
    .supply_undervoltage_flag(flg[5]), .regulator_temp_warning(flg[4]), .switch_thermal_shutdown_flag(flg[3]),
    .wake_input_two(flg[2]), .wake_input_one(flg[1]), .battery_fail_flag(flg[0]), .control_byte(control_byte),
    .slew_rate(slew_rate), .bus_pullup_connected(pu_con), .switch_on_three(sw3), .switch_on_two(sw2),
    .switch_on_one(sw1), .watchdog_clear(wd_clr), .op_mode(op_mode));
  sbcsp_monitor #(.HALF(8), .GAP(20)) sbcsp_monitor_i (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

  initial begin
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) if (wd_clr === 1'b1) wd_cnt++;
  // sample both data lines where the receivers do
  always @(posedge link.sclk) if (link.cs_n === 1'b0) begin
    mo_sh <= {mo_sh[6:0], link.mosi};
    mi_sh <= {mi_sh[6:0], link.miso};
  end

  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; waits on pready, no fixed latency assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) err_count++;
  endtask : apb

  task done_wait;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rdat[8] !== 1'b0 && n < 200);
    if (n >= 200) err_count++;
  endtask : done_wait

  task xfer(input sbcsp_row_t r);
    @(posedge pclk);
    flg <= r.flg;
    pwm_gate <= r.pwm;
    repeat (4) @(posedge pclk);
    apb(1'b1, REG_TX, {24'h0, r.ctl});
    chk("write error", 1'b0, rerr);
    done_wait();
    chk("mosi", r.ctl, mo_sh);
    chk("miso", r.est, mi_sh);
    chk("status", r.est, rdat[7:0]);
    chk("control", r.ectl, control_byte);
    chk("slew", r.eslw, slew_rate);
    chk("outputs", r.eout, {pu_con, sw3, sw2, sw1});
    chk("mode", r.emod, op_mode);
  endtask : xfer

  task finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("control reset", 8'h03, control_byte);
    apb(1'b0, REG_DIV, 32'h0);
    chk("divider", HALF_DEF, rdat);
    for (int i = 0; i < 13; i++) xfer(rows[i]);
    chk("watchdog pulses", 2, wd_cnt);
    // refusals while a frame runs must leave it untouched
    apb(1'b1, REG_TX, 32'h3F);
    apb(1'b1, REG_TX, 32'hC0);
    chk("busy refuse", 1'b1, rerr);
    apb(1'b1, REG_DIV, 32'h7);
    chk("divider refuse", 1'b1, rerr);
    apb(1'b1, 8'h0C, 32'h0);
    chk("unmapped", 1'b1, rerr);
    done_wait();
    chk("no overwrite", 8'h3F, control_byte);
    @(posedge pclk);
    dev_reset <= 1'b1;
    @(posedge pclk);
    dev_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("device reset", 8'h23, control_byte);
    xfer('{8'h03, 9'h001, 1'b1, 8'h03, 2'h0, 4'h8, 2'h0, 8'h10});
    finish_test();
  end
endmodule : tb
